// ==== hdl/ccr_core_ratio.v ====
// Contract
// - Core-to-bus ratio comes from the core ratio field of the low config word.
// - Bits 2 to 5 all zero bypass the PLL; core runs from bus clock.
// - Bits 2-5 with bit 6 select 1:1, 1.5:1, 2:1, 2.5:1 or 3:1.
// - Bits 0-1 give VCO divider: 00 div2, 01 div4, 10/11 div8.
// - While hard reset is asserted the config pins are inputs, never driven; the code keeps normal drive for up to three core_clk cycles after assertion.
// - On hard reset release the pin levels are latched and pins resume normal use.
`timescale 1ns/100ps
`include "ccr_regs.vh"

module ccr_core_ratio (
   // Clock and reset
   input  wire       core_clk,
   input  wire       resetn,
   // Hard reset from the reset source, active low, asynchronous to the clock
   input  wire       hard_reset_in_n,
   // Configuration pins, shared with normal function
   input  wire [6:0] cfg_pin_in,
   input  wire [6:0] func_out,
   input  wire [6:0] func_oe,
   output reg  [6:0] cfg_pin_out,
   output reg  [6:0] cfg_pin_oe,
   output reg        cfg_rx_en,
   // Decoded clock setup
   output reg        pll_bypass,
   output reg  [2:0] core_ratio,
   output reg  [1:0] vco_div,
   output reg        cfg_reserved,
   output reg        cfg_valid
);

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers

   reg  [1:0] hrst_sync_r;
   reg  [6:0] pin_meta_r;
   reg  [6:0] pin_sync_r;
   reg        hrst_act_r;
   reg  [6:0] core_ratio_field_r;
   wire       hrst_act;
   wire       release_evt;

   // Hard reset level through two flops before any logic sees it
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         hrst_sync_r <= `CCR_SYNC_RST;
      end else begin
         hrst_sync_r <= {hrst_sync_r[0], ~hard_reset_in_n};
      end
   end

   assign hrst_act = hrst_sync_r[1];

   // Pin levels; strapped pins are static, so per-bit sync is safe
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pin_meta_r <= `CCR_FIELD_RST;
         pin_sync_r <= `CCR_FIELD_RST;
      end else begin
         pin_meta_r <= cfg_pin_in;
         pin_sync_r <= pin_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture at hard reset release

   // Delayed copy gives the falling edge of the synced hard reset
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         hrst_act_r <= 1'b1;
      end else begin
         hrst_act_r <= hrst_act;
      end
   end

   assign release_evt = hrst_act_r & ~hrst_act;

   // Field latched once per release and then frozen
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         core_ratio_field_r <= `CCR_FIELD_RST;
      end else if (release_evt) begin
         core_ratio_field_r <= pin_sync_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode

   wire       dec_bypass;
   wire [2:0] dec_ratio;
   wire [1:0] dec_vdiv;
   wire       dec_resv;

   ccr_decode u_decode (
      .core_ratio_field (core_ratio_field_r),
      .bypass           (dec_bypass),
      .ratio            (dec_ratio),
      .vco_div          (dec_vdiv),
      .reserved         (dec_resv)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // Setup registered so it changes only after a new capture
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pll_bypass   <= 1'b0;
         core_ratio   <= `CCR_RATIO_NONE;
         vco_div      <= `CCR_VDIV_2;
         cfg_reserved <= 1'b0;
         cfg_valid    <= 1'b0;
      end else if (hrst_act) begin
         // Setup is invalid while hard reset is held
         cfg_valid    <= 1'b0;
      end else begin
         pll_bypass   <= dec_bypass;
         core_ratio   <= dec_ratio;
         vco_div      <= dec_vdiv;
         cfg_reserved <= dec_resv;
         cfg_valid    <= ~release_evt;
      end
   end

   // Pin buffer: receiver on and driver off while hard reset is asserted
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_rx_en   <= 1'b1;
         cfg_pin_out <= `CCR_FIELD_RST;
         cfg_pin_oe  <= `CCR_FIELD_RST;
      end else if (hrst_act | release_evt) begin
         cfg_rx_en   <= 1'b1;
         cfg_pin_out <= `CCR_FIELD_RST;
         cfg_pin_oe  <= `CCR_FIELD_RST;
      end else begin
         cfg_rx_en   <= 1'b0;
         cfg_pin_out <= func_out;
         cfg_pin_oe  <= func_oe;
      end
   end

endmodule

// ==== hdl/ccr_regs.vh ====
`ifndef CCR_REGS_VH
`define CCR_REGS_VH

// Width of the captured reset configuration field
`define CCR_FIELD_W      7
// Field positions inside the core ratio field
`define CCR_VDIV_LO      0
`define CCR_VDIV_HI      1
`define CCR_MULT_LO      2
`define CCR_MULT_HI      5
`define CCR_HALF_BIT     6
// Multiplier encodings (bits 2 to 5)
`define CCR_MULT_BYPASS  4'h0
`define CCR_MULT_ONE     4'h1
`define CCR_MULT_TWO     4'h2
`define CCR_MULT_THREE   4'h3
// Ratio codes, core to bus, in half steps
`define CCR_RATIO_W      3
`define CCR_RATIO_NONE   3'h0
`define CCR_RATIO_1_0    3'h1
`define CCR_RATIO_1_5    3'h2
`define CCR_RATIO_2_0    3'h3
`define CCR_RATIO_2_5    3'h4
`define CCR_RATIO_3_0    3'h5
// VCO divider codes
`define CCR_VDIV_W       2
`define CCR_VDIV_2       2'h0
`define CCR_VDIV_4       2'h1
`define CCR_VDIV_8       2'h2
// Divider select encodings (bits 0 and 1)
`define CCR_VSEL_DIV2    2'h0
`define CCR_VSEL_DIV4    2'h1
// Reset values
`define CCR_FIELD_RST    7'h00
// Hard reset taken as asserted while resetn is low, so no false release edge
`define CCR_SYNC_RST     2'h3

`endif

// ==== hdl/ccr_decode.v ====
`timescale 1ns/100ps
`include "ccr_regs.vh"

module ccr_decode (
   // Captured field
   input  wire [6:0] core_ratio_field,
   // Decoded setup
   output reg        bypass,
   output reg  [2:0] ratio,
   output reg  [1:0] vco_div,
   output reg        reserved
);

   wire [3:0] mult;
   wire       half;

   assign mult = core_ratio_field[`CCR_MULT_HI:`CCR_MULT_LO];
   assign half = core_ratio_field[`CCR_HALF_BIT];

   // Ratio and bypass decode
   always @* begin
      bypass   = 1'b0;
      reserved = 1'b0;
      ratio    = `CCR_RATIO_NONE;
      case (mult)
         `CCR_MULT_BYPASS: bypass = 1'b1;
         `CCR_MULT_ONE:    ratio = half ? `CCR_RATIO_1_5 : `CCR_RATIO_1_0;
         `CCR_MULT_TWO:    ratio = half ? `CCR_RATIO_2_5 : `CCR_RATIO_2_0;
         `CCR_MULT_THREE: begin
            // 3.5:1 is not a legal setting
            if (half) begin
               reserved = 1'b1;
            end else begin
               ratio = `CCR_RATIO_3_0;
            end
         end
         default: reserved = 1'b1;
      endcase
   end

   // VCO divider decode, both upper codes give divide by 8
   always @* begin
      case (core_ratio_field[`CCR_VDIV_HI:`CCR_VDIV_LO])
         `CCR_VSEL_DIV2: vco_div = `CCR_VDIV_2;
         `CCR_VSEL_DIV4: vco_div = `CCR_VDIV_4;
         default: vco_div = `CCR_VDIV_8;
      endcase
   end

endmodule

// ==== test/ccr_board_model.sv ====
`timescale 1ns/100ps
module ccr_board_model (
   // Board controls
   input  wire logic       hold_n,
   input  wire logic [6:0] word,
   // Device pin drive
   input  wire logic [6:0] pin_out,
   input  wire logic [6:0] pin_oe,
   // Towards the device
   output wire logic       hrst_n,
   output wire logic [6:0] pin_in
);
   // Reset source follows the bench sequencer
   assign hrst_n = hold_n;
   // Straps win only where the device leaves the pin alone
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & word);
endmodule

// ==== test/ccr_ratio_chk_assertions.sv ====
`timescale 1ns/100ps
module ccr_ratio_chk (
   // Clock and resets
   input wire logic       core_clk,
   input wire logic       resetn,
   input wire logic       hard_reset_in_n,
   // Pin side
   input wire logic [6:0] func_out,
   input wire logic [6:0] func_oe,
   input wire logic [6:0] cfg_pin_out,
   input wire logic [6:0] cfg_pin_oe,
   input wire logic       cfg_rx_en,
   // Decoded setup
   input wire logic       pll_bypass,
   input wire logic [2:0] core_ratio,
   input wire logic [1:0] vco_div,
   input wire logic       cfg_reserved,
   input wire logic       cfg_valid
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Release walk, five quiet samples
   sequence release_s;
      $rose(hard_reset_in_n) ##0 hard_reset_in_n [*5];
   endsequence
   pins_held_a: assert property (!hard_reset_in_n [*4] |-> cfg_pin_oe == 7'h00 && cfg_rx_en)
      else $error("pins driven in hard reset");
   capture_done_a: assert property (release_s |=> cfg_valid && !cfg_rx_en)
      else $error("setup late after release");
   pin_follow_a: assert property (hard_reset_in_n [*3] ##0 cfg_valid |-> cfg_pin_oe == $past(func_oe))
      else $error("pin not handed back");
   bypass_none_a: assert property (pll_bypass |-> core_ratio == 3'h0 && !cfg_reserved)
      else $error("bypass with ratio");
   ratio_legal_a: assert property (cfg_valid && !cfg_reserved |-> core_ratio <= 3'h5 && pll_bypass != |core_ratio)
      else $error("bad ratio code");
   vdiv_legal_a: assert property (cfg_valid |-> vco_div != 2'h3)
      else $error("bad divider code");
   setup_hold_a: assert property (cfg_valid && $past(cfg_valid) |-> $stable({pll_bypass, core_ratio, vco_div}))
      else $error("setup moved");
endmodule
bind ccr_core_ratio ccr_ratio_chk i_ccr_ratio_chk (.*);

// ==== test/test_core_clock_ratio_config.sv ====
`timescale 1ns/100ps
module test_core_clock_ratio_config;
   logic       core_clk = 0, resetn = 0, hold_n = 0, hrst_n, valid, byp, res, rx;
   logic [6:0] word = 7'h7F, fout = 7'h55, foe = 7'h7F, pin, pout, poe;
   logic [2:0] ratio;
   logic [1:0] vdiv;
   int         n_fail, checks_done;
   // Packed rows: field, bypass, ratio code, divider code, reserved
   logic [13:0] rows [9] = '{14'h0040, 14'h028A, 14'h2314, 14'h059C, 14'h2420, 14'h06AA, 14'h21C4, 14'h2601,
      14'h0801};
   ccr_core_ratio i_ccr_core_ratio (.core_clk(core_clk), .resetn(resetn), .hard_reset_in_n(hrst_n), .cfg_pin_in(pin),
      .func_out(fout), .func_oe(foe), .cfg_pin_out(pout), .cfg_pin_oe(poe), .cfg_rx_en(rx), .pll_bypass(byp),
      .core_ratio(ratio), .vco_div(vdiv), .cfg_reserved(res), .cfg_valid(valid));
   ccr_board_model i_ccr_board_model (.hold_n(hold_n), .word(word), .pin_out(pout), .pin_oe(poe), .hrst_n(hrst_n),
      .pin_in(pin));
   always #25 core_clk = ~core_clk;
   task check(input bit ok, input string m);
      checks_done++;
      if (!ok) begin
         n_fail++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task test_done;
      if (n_fail == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // One hard reset cycle; sampled at falling edge to dodge update races
   task boot(input logic [13:0] r);
      hold_n <= 0;
      word <= r[13:7];
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      check(poe === 7'h00 && rx === 1'b1, "pins driven");
      @(posedge core_clk);
      hold_n <= 1;
      repeat (7) @(posedge core_clk);
      @(negedge core_clk);
      check({byp, ratio, vdiv, res} === r[6:0] && valid === 1'b1 && rx === 1'b0, "decode");
      @(posedge core_clk);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      resetn <= 1;
      @(negedge core_clk);
      check(rx === 1'b1 && poe === 7'h00 && valid === 1'b0, "reset state");
      repeat (2) @(negedge core_clk);
      check(rx === 1'b1 && poe === 7'h00 && valid === 1'b0, "false release after reset");
      @(posedge core_clk);
      foreach (rows[i]) boot(rows[i]);
      // Straps and normal drive change after capture; setup must stay
      word <= 7'h05;
      fout <= 7'h33;
      foe <= 7'h0F;
      repeat (4) @(negedge core_clk);
      check({byp, ratio, vdiv, res} === rows[8][6:0] && pout === 7'h33 && poe === 7'h0F, "hold");
      test_done;
   end
   // Whole run is near 150 cycles; this is far beyond it
   initial begin
      #200000;
      n_fail++;
      test_done;
   end
endmodule
